// ---- hdl/osd_pkg.sv ----
package osd_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PROTECT = 8'h0A;
    localparam logic [7:0] IDX_PMODE0 = 8'h04;
    localparam logic [7:0] IDX_PMODE1 = 8'h05;
    localparam logic [7:0] IDX_CLK0 = 8'h06;
    localparam logic [7:0] IDX_CLK1 = 8'h07;
    localparam logic [7:0] IDX_CLK3 = 8'h09;
    localparam logic [7:0] IDX_OSD = 8'h0C;
    localparam logic [7:0] IDX_PORT0 = 8'h0E;
    localparam logic [7:0] IDX_OSC0 = 8'h23;
    localparam logic [7:0] IDX_VMON1 = 8'h31;
    localparam logic [7:0] IDX_VMON2 = 8'h32;

    // Word index sits at address bits 9:2
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Reset value shared by every register of this block
    localparam logic [7:0] REG_RESET = 8'h00;

    // Protect register bits
    localparam int PRC_CLOCK = 0;
    localparam int PRC_MODE = 1;
    localparam int PRC_PORT0 = 2;
    localparam int PRC_VOLT = 3;
    localparam int PRC_W = 4;

    // Stop detector control fields
    localparam int OSD_ONCHIP = 2;
    localparam int OSD_STOPPED = 3;
    localparam logic [1:0] OSD_ARMED = 2'h3;

    // Clock, oscillator and monitor bit positions
    localparam int CLK0_WAIT_PERIPH = 2;
    localparam int CLK0_XTAL_STOP = 5;
    localparam int CLK1_ALL_STOP = 0;
    localparam int CLK1_LOSC_STOP = 4;
    localparam int CLK3_WAIT_ENTRY = 0;
    localparam int OSC0_HS_RUN = 0;
    localparam int OSC0_SELECT = 1;
    localparam int VMON_SRC = 2;
    localparam int VMON2_WDT_SRC = 3;

    // Slow-oscillator edges per detection window
    localparam int WINDOW_EDGES = 4;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } osd_req_t;

endpackage

// ---- hdl/osd_stop_watch.sv ----
`timescale 1ns/100ps
`default_nettype none

module osd_stop_watch
    import osd_pkg::*;
#(
    parameter int WINDOW = WINDOW_EDGES
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic arm, // Detector enabled
    input wire logic xtal_edge, // One pulse per crystal edge
    input wire logic slow_edge, // One pulse per slow oscillator edge
    output logic stopped, // No crystal edge in the last window
    output logic window_end // Pulse at each window boundary
);

    ////////////////////////////////////////////////////////////////////
    localparam int CW = $clog2(WINDOW + 1);
    localparam logic [CW-1:0] LAST = CW'(WINDOW - 1);

    logic [CW-1:0] win_cnt; // Slow edges in this window
    logic seen; // Crystal edge seen in this window

    // Window ends on the last slow edge
    assign window_end = arm && slow_edge && (win_cnt == LAST);

    // Window timer, held at zero while disarmed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_cnt <= '0;
        end else if (!arm || window_end) begin
            win_cnt <= '0;
        end else if (slow_edge) begin
            win_cnt <= win_cnt + 1'b1;
        end
    end

    // Edge memory; a crystal edge at the boundary opens the next window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen <= 1'b0;
        end else if (!arm) begin
            seen <= 1'b0;
        end else if (window_end) begin
            seen <= xtal_edge;
        end else if (xtal_edge) begin
            seen <= 1'b1;
        end
    end

    // Verdict per window; a quiet window means the crystal stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stopped <= 1'b0;
        end else if (!arm) begin
            stopped <= 1'b0;
        end else if (window_end) begin
            stopped <= !seen && !xtal_edge;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/osd_supervisor.sv ----
`timescale 1ns/100ps
`default_nettype none

module osd_supervisor
    import osd_pkg::*;
#(
    parameter int WINDOW = WINDOW_EDGES
) (
    input wire logic hclk, // System clock, 125 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Only word transfers used
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data, registered
    input wire logic crystal_clock, // Crystal oscillator pin
    input wire logic slow_osc_clock, // Low-speed oscillator pin
    input wire logic watchdog_event, // Watchdog interrupt pulse
    input wire logic vmon1_event, // Voltage monitor 1 pulse
    input wire logic vmon2_event, // Voltage monitor 2 pulse
    output logic shared_irq, // Shared vector request
    output logic onchip_osc_selected_flag, // CPU on on-chip osc
    output logic crystal_stopped_flag, // Crystal stop seen
    output logic low_speed_osc_stop_bit, // Slow osc stopped
    output logic high_speed_osc_run_bit, // Fast osc running
    output logic onchip_osc_select_bit, // 1 fast, 0 slow
    output logic wait_periph_clock_stop_bit, // Periph stop in wait
    output logic crystal_stop_control_bit, // Crystal stop request
    output logic all_clocks_stop_bit, // Stop mode request
    output logic wait_entry_bit, // Wait mode request
    output logic [7:0] port0_direction // Port 0 direction
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge pulses

    logic [1:0] pin_raw; // Asynchronous pins
    logic [1:0] sync_a; // First stage, read only by second
    logic [1:0] sync_b; // Second stage
    logic [1:0] sync_c; // Delay for edge detect
    logic [1:0] pin_rise; // Rising edge pulses

    assign pin_raw = {slow_osc_clock, crystal_clock};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            // Two flops before any logic looks at the pin
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                end
            end
            assign pin_rise[gi] = sync_b[gi] && !sync_c[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Bus slave: zero-wait writes, one wait state on reads

    osd_req_t req; // Address phase held into the data phase
    logic rd_wait; // Read data being fetched
    logic accept; // Address phase taken this edge
    logic wr_go; // Write completes this edge
    logic [7:0] wdat; // Write byte
    logic [7:0] rd_val; // Read mux

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_go = req.valid && req.write;
    assign wdat = hwdata[7:0];
    assign hreadyout = !rd_wait;
    assign hresp = HRESP_OKAY;

    // Capture address phase; held while a read waits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
            rd_wait <= 1'b0;
        end else if (hready) begin
            req.valid <= accept;
            req.write <= hwrite;
            req.idx <= haddr[IDX_MSB:IDX_LSB];
            rd_wait <= accept && !hwrite;
        end else begin
            rd_wait <= 1'b0;
        end
    end

    // Read data sampled after any earlier write has landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_wait) begin
            hrdata <= {24'h00_0000, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write protection

    logic [PRC_W-1:0] protect; // Unlock bits, upper bits absent
    logic wr_protect; // Write to the protect register
    logic wr_other; // Write to any other address
    logic unlocked; // Target of this write is open

    assign wr_protect = wr_go && (req.idx == IDX_PROTECT);
    assign wr_other = wr_go && (req.idx != IDX_PROTECT);

    // Which unlock bit guards which group
    always_comb begin
        unique case (req.idx)
            IDX_CLK0, IDX_CLK1, IDX_CLK3, IDX_OSD, IDX_OSC0:
                unlocked = protect[PRC_CLOCK];
            IDX_PMODE0, IDX_PMODE1:
                unlocked = protect[PRC_MODE];
            IDX_PORT0:
                unlocked = protect[PRC_PORT0];
            IDX_VMON1, IDX_VMON2:
                unlocked = protect[PRC_VOLT];
            default:
                unlocked = 1'b0;
        endcase
    end

    // Bits 0,1,3 only change by software; bit 2 is one-shot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protect <= '0;
        end else if (wr_protect) begin
            protect <= wdat[PRC_W-1:0];
        end else if (wr_other) begin
            protect[PRC_PORT0] <= 1'b0;
        end
    end

    logic wr_ok; // Write allowed this edge
    assign wr_ok = wr_other && unlocked;

    ////////////////////////////////////////////////////////////////////
    // Plain control registers

    logic [7:0] clk0, clk1, clk3, osc0, pmode0, pmode1; // Storage
    logic stop_event; // Detector reports a fresh stop
    logic take_over; // Stop while crystal drives the CPU

    // Register stores; refused writes leave them alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk0 <= REG_RESET;
            clk3 <= REG_RESET;
            osc0 <= REG_RESET;
            pmode0 <= REG_RESET;
            pmode1 <= REG_RESET;
            port0_direction <= REG_RESET;
        end else if (wr_ok) begin
            unique case (req.idx)
                IDX_CLK0: clk0 <= wdat;
                IDX_CLK3: clk3 <= wdat;
                IDX_OSC0: osc0 <= wdat;
                IDX_PMODE0: pmode0 <= wdat;
                IDX_PMODE1: pmode1 <= wdat;
                IDX_PORT0: port0_direction <= wdat;
                default: clk0 <= clk0;
            endcase
        end
    end

    // Clock control 1; a stop while the crystal drives the CPU forces the slow oscillator on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk1 <= REG_RESET;
        end else if (take_over) begin
            clk1[CLK1_LOSC_STOP] <= 1'b0;
        end else if (wr_ok && req.idx == IDX_CLK1) begin
            clk1 <= wdat;
        end
    end

    // Stop request lasts until written back; the CPU side owns the
    // prefetch hazard after it, so no timing is added here
    assign all_clocks_stop_bit = clk1[CLK1_ALL_STOP];
    assign low_speed_osc_stop_bit = clk1[CLK1_LOSC_STOP];
    assign wait_periph_clock_stop_bit = clk0[CLK0_WAIT_PERIPH];
    assign crystal_stop_control_bit = clk0[CLK0_XTAL_STOP];
    assign wait_entry_bit = clk3[CLK3_WAIT_ENTRY];
    assign high_speed_osc_run_bit = osc0[OSC0_HS_RUN];
    assign onchip_osc_select_bit = osc0[OSC0_SELECT];

    ////////////////////////////////////////////////////////////////////
    // Oscillation stop detector

    logic [1:0] osd_en; // Detector enable field
    logic armed; // Field holds 11b
    logic det_stopped; // Detector verdict
    logic det_stopped_q; // Previous verdict
    logic win_end; // Window boundary pulse

    assign armed = (osd_en == OSD_ARMED);

    osd_stop_watch #(
        .WINDOW(WINDOW)
    ) u_watch (
        .hclk(hclk),
        .hresetn(hresetn),
        .arm(armed),
        .xtal_edge(pin_rise[0]),
        .slow_edge(pin_rise[1]),
        .stopped(det_stopped),
        .window_end(win_end)
    );

    // Fresh stop only on the verdict's rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_stopped_q <= 1'b0;
        end else begin
            det_stopped_q <= det_stopped;
        end
    end

    assign stop_event = det_stopped && !det_stopped_q;
    // Only matters while the crystal is still the CPU source
    assign take_over = stop_event && !onchip_osc_selected_flag;
    // Stopped flag follows the verdict; clears when disarmed
    assign crystal_stopped_flag = det_stopped;

    logic wr_osd; // Accepted write to detector control
    assign wr_osd = wr_ok && (req.idx == IDX_OSD);

    // Enable field is software-owned
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osd_en <= 2'h0;
        end else if (wr_osd) begin
            osd_en <= wdat[1:0];
        end
    end

    // Switch-over flag: hardware set wins over a software clear;
    // no automatic return to the crystal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            onchip_osc_selected_flag <= 1'b0;
        end else if (take_over) begin
            onchip_osc_selected_flag <= 1'b1;
        end else if (wr_osd) begin
            onchip_osc_selected_flag <= wdat[OSD_ONCHIP];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Voltage monitor registers with source flags

    logic [7:0] vmon1, vmon2; // Monitor control registers
    logic wr_vm1, wr_vm2; // Accepted writes

    assign wr_vm1 = wr_ok && (req.idx == IDX_VMON1);
    assign wr_vm2 = wr_ok && (req.idx == IDX_VMON2);

    // Source flags set by events; set beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vmon1 <= REG_RESET;
            vmon2 <= REG_RESET;
        end else begin
            if (wr_vm1) begin
                vmon1 <= wdat;
            end
            if (wr_vm2) begin
                vmon2 <= wdat;
            end
            if (vmon1_event) begin
                vmon1[VMON_SRC] <= 1'b1;
            end
            if (vmon2_event) begin
                vmon2[VMON_SRC] <= 1'b1;
            end
            if (watchdog_event) begin
                vmon2[VMON2_WDT_SRC] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared request and read mux

    logic src_clock_stop; // Clock stop source indication

    assign src_clock_stop = crystal_stopped_flag
        || (armed && onchip_osc_selected_flag);
    // One line for all four; handler tells them apart by flags
    assign shared_irq = src_clock_stop || vmon1[VMON_SRC]
        || vmon2[VMON_SRC] || vmon2[VMON2_WDT_SRC];

    // Unmapped addresses read zero
    always_comb begin
        unique case (req.idx)
            IDX_PROTECT: rd_val = {4'h0, protect};
            IDX_CLK0: rd_val = clk0;
            IDX_CLK1: rd_val = clk1;
            IDX_CLK3: rd_val = clk3;
            IDX_OSC0: rd_val = osc0;
            IDX_PMODE0: rd_val = pmode0;
            IDX_PMODE1: rd_val = pmode1;
            IDX_PORT0: rd_val = port0_direction;
            IDX_VMON1: rd_val = vmon1;
            IDX_VMON2: rd_val = vmon2;
            IDX_OSD: rd_val = {4'h0, crystal_stopped_flag,
                onchip_osc_selected_flag, osd_en};
            default: rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_disarm_quiet: assert property (
        !armed |=> !crystal_stopped_flag)
        else $error("stop reported while disarmed");
    chk_stop_takeover: assert property (take_over |=>
        onchip_osc_selected_flag && !low_speed_osc_stop_bit && shared_irq)
        else $error("stop did not switch over");
    chk_wdt_irq: assert property ($rose(vmon2[VMON2_WDT_SRC]) |->
        shared_irq) else $error("watchdog not on shared line");
    chk_armed_onchip: assert property ((armed &&
        onchip_osc_selected_flag) |-> shared_irq)
        else $error("clock stop source missing");
    chk_src_flags: assert property ((watchdog_event |=>
        vmon2[VMON2_WDT_SRC]) and (vmon1_event |=> vmon1[VMON_SRC])
        and (vmon2_event |=> vmon2[VMON_SRC]))
        else $error("source flag not set");
    chk_locked_port: assert property (wr_other &&
        req.idx == IDX_PORT0 && !protect[PRC_PORT0] |=>
        $stable(port0_direction))
        else $error("locked write took effect");
    chk_unlock_holds: assert property (protect[PRC_CLOCK] &&
        wr_other |=> protect[PRC_CLOCK])
        else $error("clock unlock dropped");
    chk_port_oneshot: assert property (protect[PRC_PORT0] &&
        wr_other |=> !protect[PRC_PORT0])
        else $error("port unlock not cleared");
    chk_protect_top: assert property (rd_wait &&
        req.idx == IDX_PROTECT |=> hrdata[31:4] == 28'h000_0000)
        else $error("protect upper bits not zero");
    chk_window_stop: assert property ($rose(det_stopped) |->
        $past(win_end)) else $error("stop outside window");

    cov_stop: cover property (take_over ##1 shared_irq);
    cov_refused: cover property (wr_other && !unlocked);
    cov_read_wait: cover property (rd_wait ##1 hreadyout);

endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb
    import osd_pkg::*;
;
    logic hclk; // Bus clock, 8 ns
    logic hresetn; // Async reset, active low
    logic [31:0] haddr; // Byte address
    logic [1:0] htrans; // Transfer type
    logic hwrite; // Write strobe
    logic [31:0] hwdata; // Write data
    logic hreadyout; // Slave ready, fed back as hready
    logic hresp; // Response, checked once for OKAY
    logic [31:0] hrdata; // Read data
    logic crystal_clock = 1'b0; // Crystal pin
    logic slow_osc_clock = 1'b0; // Slow oscillator pin
    logic [2:0] ev; // Watchdog, monitor 1, monitor 2 pulses
    logic shared_irq, onchip_flag, stop_flag, losc_stop; // Status outs
    logic hs_run, osc_sel, wait_periph, xtal_stop, all_stop, wait_in;
    logic [7:0] port0_direction; // Port 0 direction
    logic xtal_run; // Crystal oscillates when high
    logic [2:0] div = 3'h0; // Pin clock divider
    logic [31:0] rd_cap; // Last read data
    int fails; // Mismatch count
    int samples_checked; // Comparison count

    // Short window keeps the stop detection quick to see
    osd_supervisor #(.WINDOW(2)) i_osd_supervisor (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .crystal_clock(crystal_clock),
        .slow_osc_clock(slow_osc_clock), .watchdog_event(ev[2]),
        .vmon1_event(ev[1]), .vmon2_event(ev[0]), .shared_irq(shared_irq),
        .onchip_osc_selected_flag(onchip_flag),
        .crystal_stopped_flag(stop_flag), .low_speed_osc_stop_bit(losc_stop),
        .high_speed_osc_run_bit(hs_run), .onchip_osc_select_bit(osc_sel),
        .wait_periph_clock_stop_bit(wait_periph),
        .crystal_stop_control_bit(xtal_stop), .all_clocks_stop_bit(all_stop),
        .wait_entry_bit(wait_in), .port0_direction(port0_direction)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and pin oscillators; pins stay well below hclk/3
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        div <= div + 3'h1;
        // Crystal runs at a quarter of hclk, far above the 2 MHz floor
        if (xtal_run && div[0]) begin
            crystal_clock <= ~crystal_clock;
        end
        if (div == 3'h7) begin
            slow_osc_clock <= ~slow_osc_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready is looked at before the edge so the sample cannot race it
    task automatic wait_rdy();
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd_cap = hrdata;
        @(posedge hclk);
    endtask

    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [7:0] d);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(rd_cap, {24'h0, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_protect();
        rd_check(IDX_PROTECT, 8'h00);
        wr(IDX_CLK0, 8'h24);
        check(hresp, HRESP_OKAY);
        rd_check(IDX_CLK0, 8'h00);
        // Reserved bits 5:4 written as zero; bits 7:6 must read zero
        wr(IDX_PROTECT, 8'hCF);
        rd_check(IDX_PROTECT, 8'h0F);
        wr(IDX_CLK0, 8'h24);
        rd_check(IDX_CLK0, 8'h24);
        check({xtal_stop, wait_periph}, 2'b11);
        rd_check(IDX_PROTECT, 8'h0B);
        wr(IDX_PMODE0, 8'h5A);
        wr(IDX_PROTECT, 8'h04);
        wr(IDX_PMODE0, 8'h00);
        rd_check(IDX_PMODE0, 8'h5A);
        wr(IDX_PROTECT, 8'h04);
        wr(IDX_PORT0, 8'hA5);
        rd_check(IDX_PROTECT, 8'h00);
        wr(IDX_PORT0, 8'h11);
        check(port0_direction, 8'hA5);
        rd_check(8'h40, 8'h00);
        $display("test protect done");
    endtask

    task automatic test_sources();
        for (int i = 0; i < 3; i++) begin
            ev <= 3'b100 >> i;
            @(posedge hclk);
            ev <= 3'b000;
            @(posedge hclk);
        end
        rd_check(IDX_VMON2, 8'h0C);
        rd_check(IDX_VMON1, 8'h04);
        check(shared_irq, 1'b1);
        wr(IDX_VMON1, 8'h00);
        rd_check(IDX_VMON1, 8'h04);
        wr(IDX_PROTECT, 8'h08);
        wr(IDX_VMON1, 8'h00);
        wr(IDX_VMON2, 8'h00);
        wait_cyc(2);
        check(shared_irq, 1'b0);
        $display("test sources done");
    endtask

    task automatic test_detect();
        wr(IDX_PROTECT, 8'h01);
        wr(IDX_CLK1, 8'h11);
        wr(IDX_CLK3, 8'h01);
        wr(IDX_OSC0, 8'h03);
        // Let the last write land before looking at the outputs
        wait_cyc(1);
        check({losc_stop, all_stop, wait_in}, 3'h7);
        check({hs_run, osc_sel}, 2'h3);
        // Leave stop and wait, keep peripheral clocks, then arm
        wr(IDX_CLK1, 8'h10);
        wr(IDX_CLK3, 8'h00);
        wr(IDX_CLK0, 8'h00);
        // Field 01b must not arm the detector
        wr(IDX_OSD, 8'h01);
        xtal_run <= 1'b0;
        wait_cyc(200);
        check({stop_flag, onchip_flag, shared_irq}, 3'b000);
        xtal_run <= 1'b1;
        wr(IDX_OSD, 8'h03);
        wait_cyc(100);
        check(stop_flag, 1'b0);
        xtal_run <= 1'b0;
        wait_cyc(200);
        check({stop_flag, onchip_flag, losc_stop}, 3'b110);
        check(shared_irq, 1'b1);
        rd_check(IDX_OSD, 8'h0F);
        // Crystal back: settle by time, never by the stopped flag
        xtal_run <= 1'b1;
        wait_cyc(150);
        check({stop_flag, shared_irq}, 2'b01);
        // Disarmed, the kept onchip flag no longer names a source
        wr(IDX_OSD, 8'h04);
        wait_cyc(4);
        check(shared_irq, 1'b0);
        rd_check(IDX_OSD, 8'h04);
        wr(IDX_OSD, 8'h00);
        rd_check(IDX_OSD, 8'h00);
        // Slow fallback: select the slow oscillator, then arm
        wr(IDX_OSC0, 8'h01);
        wr(IDX_OSD, 8'h03);
        wait_cyc(1);
        check({osc_sel, stop_flag, shared_irq}, 3'b000);
        $display("test detect done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #40000;
        fails++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        ev = 3'b000;
        xtal_run = 1'b1;
        fails = 0;
        samples_checked = 0;
        wait_cyc(4);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_protect();
        test_sources();
        test_detect();
        final_report();
    end
endmodule

`default_nettype wire
